// ==== stf_sensor_tuning.sv ====
`timescale 1ns/1ps
`default_nettype none
module stf_sensor_tuning #(
  parameter logic [6:0] DEV_ADDR   = 7'h2A,
  // Arbitrary neutral value
  parameter logic [7:0] MAKER_CODE = 8'hA5
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Two-wire bus
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Measurement side
  input  wire logic        conv_done,
  input  wire logic        out_of_limit,
  input  wire logic [15:0] remote_raw,
  // Results and settings
  output logic [15:0]      remote_result,
  output logic             alert_flag,
  output logic             alert_oe,
  output logic             bus_timeout_enable,
  output logic [7:0]       ideality_adjust,
  output logic [1:0]       remote_average_select
);

  typedef struct packed {
    logic [2:0]             scl_sy;
    logic [2:0]             sda_sy;
    logic                   scl_f;
    logic                   sda_f;
    stf_pkg::stf_state_e    st;
    stf_pkg::stf_state_e    ack_nxt;
    logic [3:0]             cnt;
    logic [7:0]             sh;
    logic [7:0]             tx;
    logic [7:0]             ptr;
    logic                   more;
    logic                   oe;
    logic [7:0]             cfg;
    logic [7:0]             adj;
    logic [1:0]             filt;
    logic [7:0][15:0]       hist;
    logic [15:0]            result;
    logic [2:0]             run;
    logic                   alert;
  } stf_state_s;

  stf_state_s       st_reg;
  stf_state_s       st_next;
  logic             scl_rise;
  logic             scl_fall;
  logic             bus_start;
  logic             bus_stop;
  logic             wr_en;
  logic             load_tx;
  logic [11:0]      denom;
  logic [27:0]      prod;
  logic [27:0]      quot;
  logic [15:0]      corr;
  logic [7:0][15:0] h_new;
  logic [18:0]      sum4;
  logic [18:0]      sum8;
  logic [2:0]       need;
  logic [2:0]       run_inc;

  function automatic logic [7:0] rd_mux(input logic [7:0] p,
                                        input stf_state_s s);
    if (p == stf_pkg::PTR_ALERT_CFG) begin
      rd_mux = s.cfg;
    end else if (p == stf_pkg::PTR_IDEALITY) begin
      rd_mux = s.adj;
    end else if (p == stf_pkg::PTR_FILTER) begin
      rd_mux = {6'h00, s.filt};
    end else if (p == stf_pkg::PTR_MAKER) begin
      rd_mux = MAKER_CODE;
    end else begin
      rd_mux = 8'h00;
    end
  endfunction

  always_comb begin
    st_next  = st_reg;
    wr_en    = 1'b0;
    load_tx  = 1'b0;
    // Filtered fourth stage only moves once the last two synchroniser stages agree
    st_next.scl_sy = {st_reg.scl_sy[1:0], scl_in};
    st_next.sda_sy = {st_reg.sda_sy[1:0], sda_in};
    if (st_reg.scl_sy[1] == st_reg.scl_sy[2]) begin
      st_next.scl_f = st_reg.scl_sy[2];
    end
    if (st_reg.sda_sy[1] == st_reg.sda_sy[2]) begin
      st_next.sda_f = st_reg.sda_sy[2];
    end
    scl_rise  = !st_reg.scl_f && st_next.scl_f;
    scl_fall  = st_reg.scl_f && !st_next.scl_f;
    bus_start = st_reg.scl_f && st_next.scl_f &&
                st_reg.sda_f && !st_next.sda_f;
    bus_stop  = st_reg.scl_f && st_next.scl_f &&
                !st_reg.sda_f && st_next.sda_f;

    if (bus_start) begin
      st_next.st  = stf_pkg::ST_ADDR;
      st_next.cnt = 4'h0;
      st_next.oe  = 1'b0;
    end else if (bus_stop) begin
      st_next.st  = stf_pkg::ST_IDLE;
      st_next.oe  = 1'b0;
    end else if (scl_rise) begin
      case (st_reg.st)
        stf_pkg::ST_ADDR, stf_pkg::ST_PTR, stf_pkg::ST_WDATA: begin
          st_next.sh  = {st_reg.sh[6:0], st_reg.sda_f};
          st_next.cnt = st_reg.cnt + 4'h1;
        end
        stf_pkg::ST_RDATA: begin
          st_next.cnt = st_reg.cnt + 4'h1;
        end
        stf_pkg::ST_MACK: begin
          st_next.more = !st_reg.sda_f;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st_reg.st)
        stf_pkg::ST_ADDR: begin
          if (st_reg.cnt == stf_pkg::BITS_PER_BYTE) begin
            if (st_reg.sh[7:1] == DEV_ADDR) begin
              st_next.oe      = 1'b1;
              st_next.st      = stf_pkg::ST_ACK;
              st_next.ack_nxt = st_reg.sh[0] ? stf_pkg::ST_RDATA
                                             : stf_pkg::ST_PTR;
            end else begin
              st_next.st = stf_pkg::ST_IDLE;
            end
          end
        end
        stf_pkg::ST_PTR: begin
          if (st_reg.cnt == stf_pkg::BITS_PER_BYTE) begin
            st_next.ptr     = st_reg.sh;
            st_next.oe      = 1'b1;
            st_next.st      = stf_pkg::ST_ACK;
            st_next.ack_nxt = stf_pkg::ST_WDATA;
          end
        end
        stf_pkg::ST_WDATA: begin
          if (st_reg.cnt == stf_pkg::BITS_PER_BYTE) begin
            wr_en           = 1'b1;
            st_next.oe      = 1'b1;
            st_next.st      = stf_pkg::ST_ACK;
            st_next.ack_nxt = stf_pkg::ST_WDATA;
            if (st_reg.ptr == stf_pkg::PTR_ALERT_CFG) begin
              st_next.cfg = st_reg.sh;
            end else if (st_reg.ptr == stf_pkg::PTR_IDEALITY) begin
              st_next.adj = st_reg.sh;
            end else if (st_reg.ptr == stf_pkg::PTR_FILTER) begin
              st_next.filt = st_reg.sh[1:0];
            end
          end
        end
        stf_pkg::ST_ACK: begin
          st_next.cnt = 4'h0;
          st_next.st  = st_reg.ack_nxt;
          if (st_reg.ack_nxt == stf_pkg::ST_RDATA) begin
            load_tx    = 1'b1;
            st_next.tx = rd_mux(st_reg.ptr, st_reg);
            st_next.oe = !st_next.tx[7];
          end else begin
            st_next.oe = 1'b0;
          end
        end
        stf_pkg::ST_RDATA: begin
          if (st_reg.cnt == stf_pkg::BITS_PER_BYTE) begin
            st_next.oe = 1'b0;
            st_next.st = stf_pkg::ST_MACK;
          end else begin
            st_next.oe = !st_reg.tx[3'(4'h7 - st_reg.cnt)];
          end
        end
        stf_pkg::ST_MACK: begin
          // Repeated reads return the same pointer, no auto-increment
          if (st_reg.more) begin
            load_tx     = 1'b1;
            st_next.tx  = rd_mux(st_reg.ptr, st_reg);
            st_next.oe  = !st_next.tx[7];
            st_next.cnt = 4'h0;
            st_next.st  = stf_pkg::ST_RDATA;
          end else begin
            st_next.st  = stf_pkg::ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end

    // Remote result scaled by (2088 + N) / 2088, i.e. 1.008 / eta_eff
    denom = stf_pkg::IDEAL_BASE +
            {{4{st_reg.adj[7]}}, st_reg.adj};
    prod  = 28'(remote_raw) * 28'(denom);
    quot  = prod / 28'(stf_pkg::IDEAL_BASE);
    corr  = (quot > 28'h000FFFF) ? 16'hFFFF : quot[15:0];

    h_new = {st_reg.hist[6:0], corr};
    sum4  = 19'h00000;
    sum8  = 19'h00000;
    for (int i = 0; i < stf_pkg::HIST_DEPTH; i++) begin
      sum8 = sum8 + 19'(h_new[i]);
      if (i < 4) begin
        sum4 = sum4 + 19'(h_new[i]);
      end
    end

    case (st_reg.cfg[3:1])
      stf_pkg::CNT_CODE_2: need = 3'h2;
      stf_pkg::CNT_CODE_3: need = 3'h3;
      stf_pkg::CNT_CODE_4: need = 3'h4;
      default:             need = 3'h1;
    endcase
    run_inc = (st_reg.run == stf_pkg::RUN_MAX) ? stf_pkg::RUN_MAX
                                                : st_reg.run + 3'h1;

    if (conv_done) begin
      st_next.hist = h_new;
      case (st_reg.filt)
        stf_pkg::AVG_4: st_next.result = sum4[17:2];
        stf_pkg::AVG_8: st_next.result = sum8[18:3];
        default:        st_next.result = corr;
      endcase
      if (out_of_limit) begin
        st_next.run   = run_inc;
        st_next.alert = (run_inc >= need);
      end else begin
        st_next.run   = 3'h0;
        st_next.alert = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg         <= '0;
      st_reg.scl_sy  <= 3'h7;
      st_reg.sda_sy  <= 3'h7;
      st_reg.scl_f   <= 1'b1;
      st_reg.sda_f   <= 1'b1;
      st_reg.st      <= stf_pkg::ST_IDLE;
      st_reg.ack_nxt <= stf_pkg::ST_IDLE;
      st_reg.cfg     <= stf_pkg::RST_ALERT_CFG;
      st_reg.adj     <= stf_pkg::RST_IDEALITY;
      st_reg.filt    <= stf_pkg::RST_FILTER;
    end else begin
      st_reg <= st_next;
    end
  end

  // Open-drain pins only ever pull low
  assign sda_out               = 1'b0;
  assign sda_oe                = st_reg.oe;
  assign remote_result         = st_reg.result;
  assign alert_flag            = st_reg.alert;
  assign alert_oe              = st_reg.alert;
  assign bus_timeout_enable    = st_reg.cfg[stf_pkg::BIT_TIMEOUT];
  assign ideality_adjust       = st_reg.adj;
  assign remote_average_select = st_reg.filt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_timeout_write: assert property (
    (wr_en && st_reg.ptr == stf_pkg::PTR_ALERT_CFG) |=>
      bus_timeout_enable == $past(st_reg.sh[7]))
    else $error("time-out enable not taken from write");
  a_alert_reach: assert property (
    (conv_done && out_of_limit && run_inc >= need) |=> alert_flag)
    else $error("alert missing at programmed count");
  a_alert_early: assert property (
    (conv_done && out_of_limit && run_inc < need) |=> !alert_flag)
    else $error("alert raised too early");
  a_run_break: assert property (
    (conv_done && !out_of_limit) |=> (!alert_flag && st_reg.run == 3'h0))
    else $error("in-limit result did not clear run");
  a_ideal_write: assert property (
    (wr_en && st_reg.ptr == stf_pkg::PTR_IDEALITY) |=>
      ideality_adjust == $past(st_reg.sh))
    else $error("correction write lost");
  a_ideal_zero: assert property (
    (conv_done && st_reg.adj == 8'h00 && st_reg.filt == stf_pkg::AVG_OFF)
      |=> remote_result == $past(remote_raw))
    else $error("zero correction changed result");
  a_maker_read: assert property (
    (load_tx && st_reg.ptr == stf_pkg::PTR_MAKER) |=>
      st_reg.tx == MAKER_CODE)
    else $error("maker byte not returned");
  a_filter_write: assert property (
    (wr_en && st_reg.ptr == stf_pkg::PTR_FILTER) |=>
      remote_average_select == $past(st_reg.sh[1:0]))
    else $error("filter select write lost");
  a_avg_four: assert property (
    (conv_done && st_reg.filt == stf_pkg::AVG_4) |=>
      remote_result == $past(sum4[17:2]))
    else $error("four-sample mean wrong");

  c_alert_four: cover property (
    conv_done && out_of_limit && need == 3'h4 && run_inc == 3'h4);
  c_read_maker: cover property (load_tx && st_reg.ptr == stf_pkg::PTR_MAKER);
  c_avg_eight: cover property (conv_done && st_reg.filt == stf_pkg::AVG_8);
  c_neg_adjust: cover property (conv_done && st_reg.adj[7]);

endmodule // stf_sensor_tuning
`default_nettype wire

// ==== stf_pkg.sv ====
// Behaviour
// - Bit 7 of the alert-count byte turns the bus time-out on when one and off when zero, and is zero after reset.
// - The alert flag and pin rise only after the number of consecutive out-of-limit results chosen by bits 3 to 1 of the alert-count byte.
// - Count codes 0h, 1h, 3h and 7h need one, two, three and four results, and the host writes only these codes.
// - The ideality correction is a signed 8-bit value at pointer 23h, read and written there, and affects only remote results.
// - The effective ideality is 1.008 times 2088 over 2088 plus the correction, and the remote result follows from it.
// - The correction resets to 00h, so remote results are unchanged until a nonzero value is written.
// - Filter bits 1 to 0 choose no averaging, 4 or 8 remote results, and the host never writes the spare code.
// - Reading pointer FEh returns the fixed maker byte, and writes there do nothing.
// - The alert-count byte sits at pointer 22h and resets to 01h.
package stf_pkg;

  localparam logic [7:0] PTR_ALERT_CFG   = 8'h22;
  localparam logic [7:0] PTR_IDEALITY    = 8'h23;
  localparam logic [7:0] PTR_FILTER      = 8'h24;
  localparam logic [7:0] PTR_MAKER       = 8'hFE;

  localparam logic [7:0] RST_ALERT_CFG   = 8'h01;
  localparam logic [7:0] RST_IDEALITY    = 8'h00;
  localparam logic [1:0] RST_FILTER      = 2'h0;

  localparam int         BIT_TIMEOUT     = 7;
  localparam int         CNT_LSB         = 1;

  localparam logic [2:0] CNT_CODE_1      = 3'h0;
  localparam logic [2:0] CNT_CODE_2      = 3'h1;
  localparam logic [2:0] CNT_CODE_3      = 3'h3;
  localparam logic [2:0] CNT_CODE_4      = 3'h7;
  localparam logic [2:0] RUN_MAX         = 3'h4;

  localparam logic [1:0] AVG_OFF         = 2'h0;
  localparam logic [1:0] AVG_4           = 2'h1;
  localparam logic [1:0] AVG_8           = 2'h2;
  localparam int         HIST_DEPTH      = 8;

  localparam logic [11:0] IDEAL_BASE     = 12'h828;
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_PTR   = 3'b010,
    ST_WDATA = 3'b011,
    ST_ACK   = 3'b100,
    ST_RDATA = 3'b101,
    ST_MACK  = 3'b110
  } stf_state_e;

endpackage

// ==== stf_bus_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module stf_bus_host (
  // Open-drain bus
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Data moves mid-low, so no edge looks like a start or stop
  // Long low phase: the device answers some four clocks after SCL falls
  task automatic bit_io(input logic b, output logic r);
    #50 sda_pull = ~b;
    #50 scl = 1'b1;
    #40 r = sda;
    #20 scl = 1'b0;
  endtask

  task automatic byte_io(input logic [7:0] d, input logic ack_in,
                         output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
    // Stretch low so the ninth-bit driver lets go first
    #80 sda_pull = 1'b0;
  endtask

  task automatic start();
    #50 sda_pull = 1'b0;
    #30 scl = 1'b1;
    #80 sda_pull = 1'b1;
    #80 scl = 1'b0;
  endtask

  task automatic stop();
    #50 sda_pull = 1'b1;
    #30 scl = 1'b1;
    #80 sda_pull = 1'b0;
    #80;
  endtask

  task automatic write_reg(input logic [6:0] a, input logic [7:0] p,
                           input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [2:0] k;
    start();
    byte_io({a, 1'b0}, 1'b1, q, k[0]);
    byte_io(p, 1'b1, q, k[1]);
    byte_io(d, 1'b1, q, k[2]);
    stop();
    ok = ~|k;
  endtask

  task automatic read_reg(input logic [6:0] a, input logic [7:0] p,
                          output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [3:0] k;
    start();
    byte_io({a, 1'b0}, 1'b1, q, k[0]);
    byte_io(p, 1'b1, q, k[1]);
    start();
    byte_io({a, 1'b1}, 1'b1, q, k[2]);
    // One byte, refused, then stop
    byte_io(8'hFF, 1'b1, d, k[3]);
    stop();
    ok = ~|k[2:0];
  endtask
endmodule // stf_bus_host
`default_nettype wire

// ==== stf_sensor_tuning_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin \
  check_count++; \
  if ((act) !== (exp)) begin \
    err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, act, exp); \
  end \
end
module stf_sensor_tuning_test;
  localparam logic [6:0] ADDR  = 7'h2A;
  // Arbitrary maker byte
  localparam logic [7:0] MAKER = 8'h3C;

  logic        core_clk, nrst, scl, sda_pull, sda_out, sda_oe;
  wire logic   sda;
  logic        conv_done, out_of_limit, alert_flag, alert_oe;
  logic        bus_timeout_enable;
  logic [15:0] remote_raw, remote_result;
  logic [7:0]  ideality_adjust, cfg, adj;
  logic [1:0]  remote_average_select, filt;
  int          err_total, check_count, run;
  logic [19:0] exp_q[$];
  logic [19:0] rd_act, rd_exp, cv_exp;
  logic [15:0] hist[$];
  event        rd_ev;

  assign sda = ~(sda_pull | (sda_oe & ~sda_out));

  stf_sensor_tuning #(.DEV_ADDR(ADDR), .MAKER_CODE(MAKER)) dut (
    .core_clk(core_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .conv_done(conv_done),
    .out_of_limit(out_of_limit), .remote_raw(remote_raw),
    .remote_result(remote_result), .alert_flag(alert_flag),
    .alert_oe(alert_oe), .bus_timeout_enable(bus_timeout_enable),
    .ideality_adjust(ideality_adjust),
    .remote_average_select(remote_average_select)
  );
  stf_bus_host host (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Result of the conversion taken at this edge stands until the next one
  initial begin
    forever begin
      @(posedge core_clk);
      #1;
      if (conv_done === 1'b1) begin
        cv_exp = exp_q.pop_front();
        `CHK({2'b0, alert_oe, alert_flag, remote_result}, cv_exp)
      end
    end
  end

  always @(rd_ev) begin
    rd_exp = exp_q.pop_front();
    `CHK(rd_act, rd_exp)
  end

  function automatic int need(input logic [2:0] code);
    case (code)
      stf_pkg::CNT_CODE_2: return 2;
      stf_pkg::CNT_CODE_3: return 3;
      stf_pkg::CNT_CODE_4: return 4;
      default: return 1;
    endcase
  endfunction

  task automatic wr(input logic [6:0] a, input logic [7:0] p,
                    input logic [7:0] d);
    logic ok;
    @(posedge core_clk);
    #2;
    host.write_reg(a, p, d, ok);
    if (a == ADDR && p == stf_pkg::PTR_ALERT_CFG) cfg = d;
    if (a == ADDR && p == stf_pkg::PTR_IDEALITY) adj = d;
    if (a == ADDR && p == stf_pkg::PTR_FILTER) filt = d[1:0];
  endtask

  task automatic rd(input logic [7:0] p, input logic [7:0] x);
    logic [7:0] d;
    logic ok;
    @(posedge core_clk);
    #2;
    host.read_reg(ADDR, p, d, ok);
    exp_q.push_back({1'b1, cfg[7], filt, adj, x});
    rd_act = {ok, bus_timeout_enable, remote_average_select,
              ideality_adjust, d};
    ->rd_ev;
  endtask

  task automatic conv(input logic [15:0] raw, input logic oor);
    int c;
    int s;
    int n;
    c = int'(raw) * (2088 + int'($signed(adj))) / 2088;
    if (c > 65535) c = 65535;
    hist.push_front(c[15:0]);
    void'(hist.pop_back());
    n = (filt == stf_pkg::AVG_4) ? 4 : (filt == stf_pkg::AVG_8) ? 8 : 1;
    s = 0;
    for (int i = 0; i < n; i++)
      s += hist[i];
    run = oor ? ((run < 4) ? run + 1 : 4) : 0;
    conv_done = 1'b1;
    remote_raw = raw;
    out_of_limit = oor;
    exp_q.push_back({2'b0, {2{run >= need(cfg[3:1])}}, 16'(s / n)});
    @(posedge core_clk);
    #2;
  endtask

  initial begin
    logic [2:0] codes[4];
    logic [7:0] adjs[4];
    void'($urandom(64));
    codes = '{stf_pkg::CNT_CODE_1, stf_pkg::CNT_CODE_2,
              stf_pkg::CNT_CODE_3, stf_pkg::CNT_CODE_4};
    adjs = '{8'h00, 8'h80, 8'h7F, 8'($urandom)};
    nrst = 1'b0;
    conv_done = 1'b0;
    out_of_limit = 1'b0;
    remote_raw = 16'h0000;
    err_total = 0;
    check_count = 0;
    run = 0;
    cfg = 8'h01;
    adj = 8'h00;
    filt = 2'h0;
    repeat (8) hist.push_back(16'h0000);
    repeat (16) @(posedge core_clk);
    #2 nrst = 1'b1;
    repeat (4) @(posedge core_clk);
    rd(stf_pkg::PTR_ALERT_CFG, 8'h01);
    rd(stf_pkg::PTR_IDEALITY, 8'h00);
    rd(stf_pkg::PTR_FILTER, 8'h00);
    wr(ADDR, stf_pkg::PTR_MAKER, ~MAKER);
    rd(stf_pkg::PTR_MAKER, MAKER);
    wr(ADDR, 8'h30, 8'h5A);
    rd(8'h30, 8'h00);
    wr(ADDR ^ 7'h01, stf_pkg::PTR_IDEALITY, 8'h5A);
    rd(stf_pkg::PTR_IDEALITY, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR, stf_pkg::PTR_ALERT_CFG, {i[0], 3'h0, codes[i], 1'b1});
      rd(stf_pkg::PTR_ALERT_CFG, cfg);
      wr(ADDR, stf_pkg::PTR_IDEALITY, adjs[i]);
      rd(stf_pkg::PTR_IDEALITY, adj);
      wr(ADDR, stf_pkg::PTR_FILTER, {6'h00, 2'(i % 3)});
      rd(stf_pkg::PTR_FILTER, {6'h00, filt});
      @(posedge core_clk);
      #2;
      repeat (12) conv(16'($urandom), ($urandom % 4) != 0);
      conv_done = 1'b0;
      repeat (3) @(posedge core_clk);
    end
    stop_test();
  end

  // Some 33 transfers of under 10 us each, with wide margin
  initial begin
    #1_000_000;
    err_total++;
    stop_test();
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
endmodule // stf_sensor_tuning_test
`default_nettype wire
